// >>> hdl/dmac_cmd.sv
// dmac_cmd: debug command interpreter for register and memory access.
// assumes bytes arrive from the debug line transport as a valid/ready
// stream, answers leave as a valid/ready stream, and memory is reached
// through one request/acknowledge port shared by all spaces.
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module dmac_cmd
  import dmac_pkg::*;
#(
  parameter int FIFO_DEPTH = DMAC_FIFO_DEPTH
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        ce,
  // bytes received on the debug line
  input  wire logic [7:0]  rxData,
  input  wire logic        rxValid,
  output logic             rxReady,
  // bytes to send on the debug line
  output logic      [7:0]  txData,
  output logic             txValid,
  input  wire logic        txReady,
  // shared memory port
  output logic             memReq,
  output logic             memWe,
  output logic      [1:0]  memSpace,
  output logic      [15:0] memAddr,
  output logic      [7:0]  memWdata,
  input  wire logic [7:0]  memRdata,
  input  wire logic        memAck,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  dmac_state_t state_reg, state_next;
  logic [7:0]  opcode_reg, opcode_next;
  logic [2:0]  hdrIdx_reg, hdrIdx_next;
  logic [15:0] addr_reg, addr_next;
  logic [7:0]  sizeHi_reg, sizeHi_next;
  logic [16:0] remain_reg, remain_next;
  logic [7:0]  txData_reg, txData_next;
  logic        txValid_reg, txValid_next;
  logic        memReq_reg, memReq_next;
  logic        memWe_reg, memWe_next;
  logic [7:0]  memWdata_reg, memWdata_next;
  logic [2:0]  ctrl_reg;
  logic [31:0] regRdata_reg;
  logic [7:0]  fifoData;
  logic        fifoValid;
  logic        fifoPop;

  ////////////////////////////////////////////////////////////////////////
  // receive buffer; the parser stalls during memory waits so it fills
  dmac_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clock    (clock),
    .rstn     (rstn),
    .ce       (ce),
    .inData   (rxData),
    .inValid  (rxValid),
    .inReady  (rxReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (fifoPop)
  );

  ////////////////////////////////////////////////////////////////////////
  // decode of control and opcode
  wire debugOn   = ctrl_reg[DMAC_CTRL_DEBUG];
  wire protectOn = ctrl_reg[DMAC_CTRL_PROTECT];
  wire unlockOn  = ctrl_reg[DMAC_CTRL_UNLOCK];
  wire guarded   = !debugOn || protectOn;

  wire isRegRd   = (opcode_reg == DMAC_OP_REG_RD);
  wire isProgWr  = (opcode_reg == DMAC_OP_PROG_WR);
  wire isProgRd  = (opcode_reg == DMAC_OP_PROG_RD);
  wire isDataWr  = (opcode_reg == DMAC_OP_DATA_WR);
  wire isRead    = isRegRd || isProgRd;

  wire knownOp   = (fifoData == DMAC_OP_REG_RD)
                || (fifoData == DMAC_OP_PROG_WR)
                || (fifoData == DMAC_OP_PROG_RD)
                || (fifoData == DMAC_OP_DATA_WR);

  // write is dropped when guarded, or for a program write while the flash is still locked
  wire dropWr    = guarded || (isProgWr && !unlockOn);

  wire [2:0] hdrLen  = isRegRd ? DMAC_HDR_LEN_REG : DMAC_HDR_LEN_MEM;
  wire       hdrLast = (hdrIdx_reg == hdrLen - 3'h1);
  wire       lastByte = (remain_reg == 17'h00001);

  // count for the final header byte, zero size means full range
  wire [15:0] sizeRaw = isRegRd ? {8'h00, fifoData}
                                : {sizeHi_reg, fifoData};
  wire [16:0] maxCnt  = isRegRd ? DMAC_MAX_REG_CNT : DMAC_MAX_MEM_CNT;
  wire [16:0] startCnt = (sizeRaw == 16'h0000) ? maxCnt
                                               : {1'b0, sizeRaw};

  // memory space per command
  wire [1:0] spaceSel = isRegRd  ? DMAC_SPACE_REG
                      : isDataWr ? DMAC_SPACE_DATA
                                 : DMAC_SPACE_PROG;

  // bytes are only taken while the parser can act on them
  assign fifoPop = fifoValid && ((state_reg == DMAC_IDLE)
                            || (state_reg == DMAC_HDR)
                            || (state_reg == DMAC_WR_DATA));

  ////////////////////////////////////////////////////////////////////////
  // command sequencer next state
  always_comb begin
    state_next    = state_reg;
    opcode_next   = opcode_reg;
    hdrIdx_next   = hdrIdx_reg;
    addr_next     = addr_reg;
    sizeHi_next   = sizeHi_reg;
    remain_next   = remain_reg;
    txData_next   = txData_reg;
    txValid_next  = txValid_reg;
    memReq_next   = memReq_reg;
    memWe_next    = memWe_reg;
    memWdata_next = memWdata_reg;
    case (state_reg)
      DMAC_IDLE: begin
        // unknown opcodes are swallowed so the stream resyncs
        if (fifoPop && knownOp) begin
          opcode_next = fifoData;
          hdrIdx_next = 3'h0;
          state_next  = DMAC_HDR;
        end
      end
      DMAC_HDR: begin
        if (fifoPop) begin
          hdrIdx_next = hdrIdx_reg + 3'h1;
          case (hdrIdx_reg)
            3'h0: begin
              if (isRegRd) begin
                addr_next = {4'h0, fifoData[3:0], 8'h00};
              end else begin
                addr_next = {fifoData, 8'h00};
              end
            end
            3'h1: begin
              addr_next = {addr_reg[15:8], fifoData};
            end
            3'h2: begin
              sizeHi_next = fifoData;
            end
            default: begin
            end
          endcase
          if (hdrLast) begin
            remain_next = startCnt;
            state_next  = isRead ? DMAC_RD_REQ : DMAC_WR_DATA;
          end
        end
      end
      DMAC_RD_REQ: begin
        if (guarded) begin
          txData_next  = DMAC_FILL_BYTE;
          txValid_next = 1'b1;
          state_next   = DMAC_SEND;
        end else begin
          memReq_next = 1'b1;
          memWe_next  = 1'b0;
          state_next  = DMAC_RD_WAIT;
        end
      end
      DMAC_RD_WAIT: begin
        if (memAck) begin
          memReq_next  = 1'b0;
          txData_next  = memRdata;
          txValid_next = 1'b1;
          state_next   = DMAC_SEND;
        end
      end
      DMAC_SEND: begin
        if (txReady) begin
          txValid_next = 1'b0;
          addr_next    = addr_reg + 16'h0001;
          remain_next  = remain_reg - 17'h00001;
          state_next   = lastByte ? DMAC_IDLE : DMAC_RD_REQ;
        end
      end
      DMAC_WR_DATA: begin
        if (fifoPop) begin
          if (dropWr) begin
            // dropped bytes still count and step the address
            addr_next   = addr_reg + 16'h0001;
            remain_next = remain_reg - 17'h00001;
            state_next  = lastByte ? DMAC_IDLE : DMAC_WR_DATA;
          end else begin
            memReq_next   = 1'b1;
            memWe_next    = 1'b1;
            memWdata_next = fifoData;
            state_next    = DMAC_WR_WAIT;
          end
        end
      end
      DMAC_WR_WAIT: begin
        if (memAck) begin
          memReq_next = 1'b0;
          memWe_next  = 1'b0;
          addr_next   = addr_reg + 16'h0001;
          remain_next = remain_reg - 17'h00001;
          state_next  = lastByte ? DMAC_IDLE : DMAC_WR_DATA;
        end
      end
      default: begin
        state_next   = DMAC_IDLE;
        memReq_next  = 1'b0;
        txValid_next = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg    <= DMAC_IDLE;
      opcode_reg   <= 8'h00;
      hdrIdx_reg   <= 3'h0;
      addr_reg     <= 16'h0000;
      sizeHi_reg   <= 8'h00;
      remain_reg   <= 17'h00000;
    end else if (ce) begin
      state_reg    <= state_next;
      opcode_reg   <= opcode_next;
      hdrIdx_reg   <= hdrIdx_next;
      addr_reg     <= addr_next;
      sizeHi_reg   <= sizeHi_next;
      remain_reg   <= remain_next;
    end
  end

  // output flops toward the line and the memory port
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      txData_reg   <= 8'h00;
      txValid_reg  <= 1'b0;
      memReq_reg   <= 1'b0;
      memWe_reg    <= 1'b0;
      memWdata_reg <= 8'h00;
    end else if (ce) begin
      txData_reg   <= txData_next;
      txValid_reg  <= txValid_next;
      memReq_reg   <= memReq_next;
      memWe_reg    <= memWe_next;
      memWdata_reg <= memWdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register port; unmapped addresses read zero, writes ignored
  wire ctrlHit = (regAddr == DMAC_OFS_CTRL);

  wire [31:0] statusWord = {16'h0000, 1'b0, state_reg, opcode_reg};
  wire [31:0] rdMux = (regAddr == DMAC_OFS_CTRL)   ? {29'h0, ctrl_reg}
                    : (regAddr == DMAC_OFS_STATUS) ? statusWord
                    : (regAddr == DMAC_OFS_REMAIN) ? {15'h0, remain_reg}
                    : (regAddr == DMAC_OFS_ADDR)   ? {16'h0, addr_reg}
                    : 32'h00000000;

  // guard bits may change mid command; they apply to the next byte
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg     <= DMAC_CTRL_RESET;
      regRdata_reg <= 32'h00000000;
    end else if (ce) begin
      if (regWr && ctrlHit) ctrl_reg <= regWdata[2:0];
      if (regRd) regRdata_reg <= rdMux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  assign txData   = txData_reg;
  assign txValid  = txValid_reg;
  assign memReq   = memReq_reg;
  assign memWe    = memWe_reg;
  assign memAddr  = addr_reg;
  assign memWdata = memWdata_reg;
  assign regRdata = regRdata_reg;

  // space follows the opcode register, stable through a command
  logic [1:0] memSpace_reg;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      memSpace_reg <= DMAC_SPACE_REG;
    end else if (ce) begin
      memSpace_reg <= spaceSel;
    end
  end
  assign memSpace = memSpace_reg;

endmodule

// >>> hdl/dmac_pkg.sv
// dmac_pkg: constants shared by the debug memory access command block.
// assumes a byte stream from the debug line transport and a simple
// request/acknowledge memory port toward the cpu memory paths.
package dmac_pkg;

  ////////////////////////////////////////////////////////////////////////
  // command opcodes
  localparam logic [7:0] DMAC_OP_REG_RD  = 8'h09;
  localparam logic [7:0] DMAC_OP_PROG_WR = 8'h0a;
  localparam logic [7:0] DMAC_OP_PROG_RD = 8'h0b;
  localparam logic [7:0] DMAC_OP_DATA_WR = 8'h0c;

  // byte returned for every requested byte while reads are guarded
  localparam logic [7:0] DMAC_FILL_BYTE  = 8'hff;

  // header bytes after the opcode
  localparam logic [2:0] DMAC_HDR_LEN_REG = 3'h3;
  localparam logic [2:0] DMAC_HDR_LEN_MEM = 3'h4;

  // byte counts for a size field of zero
  localparam logic [16:0] DMAC_MAX_REG_CNT = 17'h00100;
  localparam logic [16:0] DMAC_MAX_MEM_CNT = 17'h10000;

  ////////////////////////////////////////////////////////////////////////
  // memory space select on the shared memory port
  localparam logic [1:0] DMAC_SPACE_REG  = 2'h0; // register file
  localparam logic [1:0] DMAC_SPACE_PROG = 2'h1; // load constant path
  localparam logic [1:0] DMAC_SPACE_DATA = 2'h2; // load external path

  ////////////////////////////////////////////////////////////////////////
  // register port map and fields
  localparam logic [7:0] DMAC_OFS_CTRL   = 8'h00;
  localparam logic [7:0] DMAC_OFS_STATUS = 8'h04;
  localparam logic [7:0] DMAC_OFS_REMAIN = 8'h08;
  localparam logic [7:0] DMAC_OFS_ADDR   = 8'h0c;

  localparam int DMAC_CTRL_DEBUG   = 0; // chip in debug mode
  localparam int DMAC_CTRL_PROTECT = 1; // read protect option active
  localparam int DMAC_CTRL_UNLOCK  = 2; // flash controller unlocked

  localparam logic [2:0] DMAC_CTRL_RESET = 3'h0;

  // fifo depth in front of the parser
  localparam int DMAC_FIFO_DEPTH = 4;

  ////////////////////////////////////////////////////////////////////////
  // command sequencer states, one-hot
  typedef enum logic [6:0] {
    DMAC_IDLE    = 7'h01,
    DMAC_HDR     = 7'h02,
    DMAC_RD_REQ  = 7'h04,
    DMAC_RD_WAIT = 7'h08,
    DMAC_SEND    = 7'h10,
    DMAC_WR_DATA = 7'h20,
    DMAC_WR_WAIT = 7'h40
  } dmac_state_t;

endpackage

// >>> hdl/dmac_fifo.sv
// dmac_fifo: small first-in first-out buffer with valid/ready on both
// sides. assumes one clock, asynchronous active-low reset and a clock
// enable that freezes all state.
`timescale 1ns/1ps
module dmac_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] memArr [DEPTH];
  logic [AW-1:0]    wrPtr_reg;
  logic [AW-1:0]    rdPtr_reg;
  logic [CW-1:0]    count_reg;
  logic [CW-1:0]    count_next;
  logic             ready_reg;

  ////////////////////////////////////////////////////////////////////////
  // handshakes; ready is a flop so the port stays glitch free
  wire push = inValid & ready_reg;
  wire pop  = outValid & outReady;

  assign inReady    = ready_reg;
  assign outValid   = (count_reg != '0);
  assign outData    = memArr[rdPtr_reg];
  assign count_next = count_reg + CW'(push) - CW'(pop);

  // pointer wrap, depth need not be a power of two
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  // storage has no reset, only the pointers, count and ready do
  always_ff @(posedge clock) begin
    if (ce && push) begin
      memArr[wrPtr_reg] <= inData;
    end
  end

  // pointers, fill count and registered ready
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
      ready_reg <= 1'b0;
    end else if (ce) begin
      if (push) wrPtr_reg <= bump(wrPtr_reg);
      if (pop)  rdPtr_reg <= bump(rdPtr_reg);
      count_reg <= count_next;
      ready_reg <= (count_next != FULL_CNT);
    end
  end

endmodule

// >>> testbench/dmac_mem_model.sv
// dmac_mem_model: memory behind the shared port of dmac_cmd.
// assumes one clock; ack comes lat cycles after a request is seen.
`timescale 1ns/1ps
module dmac_mem_model
  import dmac_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        memReq,
  input  wire logic        memWe,
  input  wire logic [1:0]  memSpace,
  input  wire logic [15:0] memAddr,
  input  wire logic [7:0]  memWdata,
  input  wire logic [1:0]  lat,
  output logic      [7:0]  memRdata,
  output logic             memAck
);
  logic [7:0] mem [0:2][0:65535];
  logic [1:0] waitCnt_reg;
  // one access at a time; read data toggles outside the ack cycle so a
  // late sample of the bus never sees a stale byte
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      memAck      <= 1'b0;
      memRdata    <= 8'h00;
      waitCnt_reg <= 2'h0;
    end else if (memAck || !memReq) begin
      memAck      <= 1'b0;
      memRdata    <= ~memRdata;
      waitCnt_reg <= lat;
    end else if (waitCnt_reg != 2'h0) begin
      memRdata    <= ~memRdata;
      waitCnt_reg <= waitCnt_reg - 2'h1;
    end else begin
      memAck   <= 1'b1;
      memRdata <= mem[memSpace][memAddr];
      if (memWe) mem[memSpace][memAddr] <= memWdata;
    end
  end
endmodule

// >>> testbench/dmac_cmd_checker.sv
// dmac_cmd_checker: port-level properties of the command interpreter.
// assumes it is bound into dmac_cmd and sees only its ports.
`timescale 1ns/1ps
module dmac_cmd_checker
  import dmac_pkg::*;
#(
  parameter int FIFO_DEPTH = DMAC_FIFO_DEPTH
) (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        ce,
  input wire logic [7:0]  rxData,
  input wire logic        rxValid,
  input wire logic        rxReady,
  input wire logic [7:0]  txData,
  input wire logic        txValid,
  input wire logic        txReady,
  input wire logic        memReq,
  input wire logic        memWe,
  input wire logic [1:0]  memSpace,
  input wire logic [15:0] memAddr,
  input wire logic [7:0]  memWdata,
  input wire logic [7:0]  memRdata,
  input wire logic        memAck,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [31:0] regRdata
);
  logic [2:0] ctrl_reg;
  logic [7:0] rdHold_reg;
  logic       guardOpen;
  // mirror of control bits and of the last byte read from memory
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg   <= 3'h0;
      rdHold_reg <= 8'h00;
    end else begin
      if (ce && regWr && regAddr == DMAC_OFS_CTRL) ctrl_reg <= regWdata[2:0];
      if (memReq && memAck && !memWe) rdHold_reg <= memRdata;
    end
  end
  // access allowed only in debug mode without read protect
  assign guardOpen = ctrl_reg[DMAC_CTRL_DEBUG] && !ctrl_reg[DMAC_CTRL_PROTECT];
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  a_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txData))
    else $error("tx byte changed before taken");
  a_mem_hold: assert property (memReq && !memAck |=> memReq && $stable({memWe, memSpace, memAddr, memWdata}))
    else $error("memory request changed before ack");
  a_mem_release: assert property (memReq && memAck |=> !memReq)
    else $error("memory request held past ack");
  // writes step on the ack, reads only once the byte is taken
  a_addr_step: assert property (memReq && memAck && memWe |=> memAddr == $past(memAddr) + 16'h1)
    else $error("address did not step after write");
  a_addr_rdstep: assert property (txValid && txReady |=> memAddr == $past(memAddr) + 16'h1)
    else $error("address did not step after send");
  a_guard_nomem: assert property (memReq |-> guardOpen)
    else $error("memory access while guarded");
  a_lock_drop: assert property (memReq && memWe && memSpace == DMAC_SPACE_PROG |-> ctrl_reg[DMAC_CTRL_UNLOCK])
    else $error("program write while locked");
  a_guard_fill: assert property (txValid && !guardOpen |-> txData == DMAC_FILL_BYTE)
    else $error("guarded read returned real data");
  a_read_return: assert property (memReq && memAck && !memWe |-> ##[1:4] (txValid && txData == rdHold_reg))
    else $error("read byte not forwarded");
  a_regfile_ro: assert property (memReq && memSpace == DMAC_SPACE_REG |-> !memWe)
    else $error("write toward register file");
  c_mem_write: cover property (memReq && memAck && memWe);
  c_mem_read: cover property (memReq && memAck && !memWe);
  c_fill_sent: cover property (txValid && txReady && !guardOpen);
endmodule

bind dmac_cmd dmac_cmd_checker #(.FIFO_DEPTH(FIFO_DEPTH)) dmac_cmd_checker_i (
  .clock, .rstn, .ce, .rxData, .rxValid, .rxReady, .txData, .txValid,
  .txReady, .memReq, .memWe, .memSpace, .memAddr, .memWdata, .memRdata,
  .memAck, .regAddr, .regWdata, .regWr, .regRd, .regRdata);

// >>> testbench/tb_top.sv
// tb_top: self-checking bench for dmac_cmd with a memory model.
// assumes the package constants and one 50 MHz clock.
`timescale 1ns/1ps
module tb_top
  import dmac_pkg::*;
;
  logic        clock, rstn, ce, rxValid, rxReady, txValid, txReady;
  logic        memReq, memWe, memAck, regWr, regRd;
  logic [1:0]  memSpace, lat;
  logic [7:0]  rxData, txData, memWdata, memRdata, regAddr;
  logic [15:0] memAddr;
  logic [31:0] regWdata, regRdata, d, seed, txSeed;
  logic [7:0]  txq[$], wb[$], e[$];
  int          mismatches = 0, n_checks = 0;

  dmac_cmd dmac_cmd_i (.clock, .rstn, .ce, .rxData, .rxValid, .rxReady,
    .txData, .txValid, .txReady, .memReq, .memWe, .memSpace, .memAddr,
    .memWdata, .memRdata, .memAck, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata);
  dmac_mem_model dmac_mem_model_i (.clock, .rstn, .memReq, .memWe,
    .memSpace, .memAddr, .memWdata, .lat, .memRdata, .memAck);

  ////////////////////////////////////////////////////////////////////////
  always #10 clock = ~clock;
  // random sink stalls and memory latency; taken bytes are queued
  always @(posedge clock) begin
    if (txValid && txReady) txq.push_back(txData);
    txSeed = lfsr(txSeed);
    txReady <= txSeed[0] | txSeed[1];
    lat <= txSeed[3:2];
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // preset memory contents, distinct per space
  function automatic logic [7:0] expByte(input logic [1:0] s,
                                         input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ {s, 6'h15};
  endfunction

  task automatic end_of_test();
    if (mismatches == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic regWrite(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
  endtask
  // read data is loaded on the strobe edge and held until the next strobe
  task automatic regRead(input logic [7:0] a);
    @(posedge clock);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    @(negedge clock);
    d = regRdata;
  endtask
  // held until an edge sees rxReady; valid stays up for the next byte
  task automatic sendByte(input logic [7:0] b);
    int   n;
    logic rdy;
    rxData <= b;
    rxValid <= 1'b1;
    n = 0;
    do begin
      @(negedge clock);
      rdy = rxReady;
      @(posedge clock);
      n++;
    end while (!rdy && n < 300);
    if (!rdy) begin
      mismatches++;
      end_of_test();
    end
  endtask
  task automatic cmd(input logic [7:0] op, input logic [15:0] a,
                     input logic [15:0] sz, input int nd);
    @(posedge clock);
    sendByte(op);
    if (op == DMAC_OP_REG_RD) begin
      sendByte({4'h0, a[11:8]});
      sendByte(a[7:0]);
      sendByte(sz[7:0]);
    end else begin
      sendByte(a[15:8]);
      sendByte(a[7:0]);
      sendByte(sz[15:8]);
      sendByte(sz[7:0]);
    end
    wb = {};
    repeat (nd) begin
      seed = lfsr(seed);
      wb.push_back(seed[7:0]);
      sendByte(seed[7:0]);
    end
    rxValid <= 1'b0;
  endtask
  task automatic mkExp(input logic [1:0] s, input logic [15:0] a,
                       input int n, input logic g);
    e = {};
    for (int i = 0; i < n; i++)
      e.push_back(g ? DMAC_FILL_BYTE : expByte(s, a + 16'(i)));
  endtask
  // waits for the answer, then allows time for any surplus byte
  task automatic getTx();
    int k;
    for (k = 0; k < 40 * e.size() + 100 && txq.size() < e.size(); k++)
      @(posedge clock);
    repeat (10) @(posedge clock);
    chk("txCount", e.size(), txq.size());
    if (txq.size() < e.size()) end_of_test();
    foreach (e[i]) chk("txData", e[i], txq.pop_front());
    txq = {};
  endtask
  task automatic chkMem(input logic [1:0] s, input logic [15:0] a,
                        input logic [7:0] q[$]);
    repeat (40) @(posedge clock);
    foreach (q[i]) chk("memByte", q[i], dmac_mem_model_i.mem[s][a + i]);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    rstn = 1'b0;
    ce = 1'b1;
    rxData = 8'h00;
    rxValid = 1'b0;
    txReady = 1'b0;
    lat = 2'h0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    seed = 32'hf45e;
    txSeed = 32'hf45e;
    for (int s = 0; s < 3; s++)
      for (int a = 0; a < 65536; a++)
        dmac_mem_model_i.mem[s][a] = expByte(s[1:0], a[15:0]);
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    repeat (2) @(posedge clock);
    regRead(DMAC_OFS_CTRL);
    chk("ctrlReset", 32'h0, d);
    regRead(8'h40);
    chk("unmapped", 32'h0, d);
    // guarded: outside debug, then debug with read protect
    mkExp(0, 0, 3, 1);
    cmd(DMAC_OP_REG_RD, 16'h0123, 16'h0003, 0);
    getTx();
    regWrite(DMAC_OFS_CTRL, 32'h3);
    cmd(DMAC_OP_REG_RD, 16'h0123, 16'h0003, 0);
    getTx();
    cmd(DMAC_OP_PROG_RD, 16'h0400, 16'h0003, 0);
    getTx();
    mkExp(2, 16'h0500, 3, 0);
    cmd(DMAC_OP_DATA_WR, 16'h0500, 16'h0002, 2);
    chkMem(2, 16'h0500, e);
    // debug mode, flash still locked
    regWrite(DMAC_OFS_CTRL, 32'h1);
    mkExp(1, 16'h1230, 4, 0);
    cmd(DMAC_OP_PROG_WR, 16'h1230, 16'h0003, 3);
    chkMem(1, 16'h1230, e);
    // stray opcode, then a full 256 byte register read
    @(posedge clock);
    sendByte(8'h55);
    rxValid <= 1'b0;
    mkExp(0, 16'h0700, 256, 0);
    cmd(DMAC_OP_REG_RD, 16'h0700, 16'h0000, 0);
    getTx();
    regWrite(DMAC_OFS_CTRL, 32'h5);
    cmd(DMAC_OP_PROG_WR, 16'h1230, 16'h0005, 5);
    chkMem(1, 16'h1230, wb);
    e = wb;
    cmd(DMAC_OP_PROG_RD, 16'h1230, 16'h0005, 0);
    getTx();
    regRead(DMAC_OFS_ADDR);
    chk("addrEnd", 32'h00001235, d);
    regRead(DMAC_OFS_STATUS);
    chk("status", {17'h0, 7'(DMAC_IDLE), DMAC_OP_PROG_RD}, d);
    cmd(DMAC_OP_DATA_WR, 16'h2340, 16'h0004, 4);
    e = wb;
    e.push_back(expByte(2, 16'h2344));
    chkMem(2, 16'h2340, e);
    // zero size means the full 16-bit count; abort by reset mid-command
    cmd(DMAC_OP_PROG_WR, 16'h3000, 16'h0000, 0);
    repeat (6) @(posedge clock);
    regRead(DMAC_OFS_REMAIN);
    chk("remain", 32'h10000, d);
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    repeat (2) @(posedge clock);
    regRead(DMAC_OFS_CTRL);
    chk("ctrlAgain", 32'h0, d);
    // a write while the clock enable is low must leave control alone
    ce <= 1'b0;
    regWrite(DMAC_OFS_CTRL, 32'h1);
    ce <= 1'b1;
    regRead(DMAC_OFS_CTRL);
    chk("ceFreeze", 32'h0, d);
    mkExp(0, 0, 2, 1);
    cmd(DMAC_OP_REG_RD, 16'h0010, 16'h0002, 0);
    getTx();
    end_of_test();
  end
endmodule
